/* File: light_sensor_irq_and_data_regs.v */
`timescale 1ns/100ps
`include "light_sensor_consts.vh"

module light_sensor_irq_and_data_regs #(
  parameter [6:0] BUS_ADDR = `BUS_ADDR_DEFAULT
) (
  input wire core_clk,
  input wire rstn,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire conv_done,
  input wire [15:0] chan0_sample,
  input wire [15:0] chan1_sample,
  output wire int_n
);

  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_ACKA = 7'h04;
  localparam [6:0] ST_WR = 7'h08;
  localparam [6:0] ST_ACKW = 7'h10;
  localparam [6:0] ST_RD = 7'h20;
  localparam [6:0] ST_ACKR = 7'h40;

  reg scl_s1, scl_s2, scl_s3;
  reg sda_s1, sda_s2, sda_s3;
  reg [6:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] tx_reg;
  reg rw_reg;
  reg first_reg;
  reg [3:0] wr_idx_reg;
  reg [3:0] rd_idx_reg;
  reg sda_oe_reg;
  reg [7:0] command_reg;
  reg clear_reg;
  reg [7:0] irq_control_reg;
  reg [15:0] low_limit_reg;
  reg [15:0] high_limit_reg;
  reg [15:0] chan0_result_reg;
  reg [15:0] chan1_result_reg;
  reg [7:0] chan0_shadow_reg;
  reg [7:0] chan1_shadow_reg;
  reg [3:0] persist_cnt_reg;
  reg pending_reg;
  reg int_n_reg;
  reg [7:0] rd_data;

  // Synchronised bus lines; stage 3 only feeds edge detection
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  wire scl_rise = scl_s2 & ~scl_s3;
  wire scl_fall = ~scl_s2 & scl_s3;
  wire bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  wire bus_stop = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  wire byte_done = (bit_cnt_reg == `BITS_PER_BYTE);

  wire [3:0] ptr = command_reg[3:0];
  wire [3:0] rd_addr = ptr + rd_idx_reg;
  wire [3:0] wr_addr = ptr + wr_idx_reg;
  wire [1:0] mode = irq_control_reg[`MODE_MSB:`MODE_LSB];
  wire [3:0] persist = irq_control_reg[`PERSIST_MSB:`PERSIST_LSB];

  wire load_rd = scl_fall & ~bus_start & ~bus_stop &
    (((state_reg == ST_ACKA) & rw_reg) | (state_reg == ST_ACKR));

  // Read mux; channel high bytes come from the shadows
  always @* begin
    case (rd_addr)
      `OFS_LOW_LIMIT_LO: rd_data = low_limit_reg[7:0];
      `OFS_LOW_LIMIT_HI: rd_data = low_limit_reg[15:8];
      `OFS_HIGH_LIMIT_LO: rd_data = high_limit_reg[7:0];
      `OFS_HIGH_LIMIT_HI: rd_data = high_limit_reg[15:8];
      `OFS_IRQ_CONTROL: rd_data = irq_control_reg;
      `OFS_PART_IDENTITY:
        rd_data = {`PART_CODE_VALUE, `SILICON_REV_VALUE};
      `OFS_CHAN0_LOW: rd_data = chan0_result_reg[7:0];
      `OFS_CHAN0_HIGH: rd_data = chan0_shadow_reg;
      `OFS_CHAN1_LOW: rd_data = chan1_result_reg[7:0];
      `OFS_CHAN1_HIGH: rd_data = chan1_shadow_reg;
      default: rd_data = 8'h00;
    endcase
  end

  // Bus slave and register writes
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      wr_idx_reg <= 4'h0;
      rd_idx_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
      command_reg <= `COMMAND_RESET;
      clear_reg <= 1'b0;
      irq_control_reg <= `IRQ_CONTROL_RESET;
      low_limit_reg <= `LIMIT_RESET;
      high_limit_reg <= `LIMIT_RESET;
      chan0_shadow_reg <= 8'h00;
      chan1_shadow_reg <= 8'h00;
    end else begin
      clear_reg <= 1'b0;
      if (bus_start) begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_reg <= 1'b0;
        first_reg <= 1'b1;
        wr_idx_reg <= 4'h0;
        rd_idx_reg <= 4'h0;
      end else if (bus_stop) begin
        state_reg <= ST_IDLE;
        sda_oe_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sda_oe_reg <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s2};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && byte_done) begin
              if (shift_reg[7:1] == BUS_ADDR) begin
                rw_reg <= shift_reg[0];
                sda_oe_reg <= 1'b1;
                state_reg <= ST_ACKA;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          // Write: the ACK ends on the next SCL fall, data bytes follow
          ST_ACKA: begin
            if (scl_fall && !rw_reg) begin
              sda_oe_reg <= 1'b0;
              bit_cnt_reg <= 4'h0;
              state_reg <= ST_WR;
            end
          end
          ST_WR: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s2};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && byte_done) begin
              sda_oe_reg <= 1'b1;
              state_reg <= ST_ACKW;
              first_reg <= 1'b0;
              if (first_reg && shift_reg[`CMD_SELECT_BIT]) begin
                command_reg <= {shift_reg[7], 1'b0, shift_reg[5:0]};
                clear_reg <= shift_reg[`CMD_CLEAR_BIT];
              end else begin
                wr_idx_reg <= wr_idx_reg + 4'h1;
                case (wr_addr)
                  `OFS_LOW_LIMIT_LO: low_limit_reg[7:0] <= shift_reg;
                  `OFS_LOW_LIMIT_HI: low_limit_reg[15:8] <= shift_reg;
                  `OFS_HIGH_LIMIT_LO: high_limit_reg[7:0] <= shift_reg;
                  `OFS_HIGH_LIMIT_HI: high_limit_reg[15:8] <= shift_reg;
                  `OFS_IRQ_CONTROL: irq_control_reg <= {2'h0, shift_reg[5:0]};
                  default: ;
                endcase
              end
            end
          end
          ST_ACKW: begin
            if (scl_fall) begin
              sda_oe_reg <= 1'b0;
              bit_cnt_reg <= 4'h0;
              state_reg <= ST_WR;
            end
          end
          ST_RD: begin
            if (scl_rise) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall) begin
              if (byte_done) begin
                sda_oe_reg <= 1'b0;
                state_reg <= ST_ACKR;
              end else begin
                tx_reg <= {tx_reg[6:0], 1'b0};
                sda_oe_reg <= ~tx_reg[6];
              end
            end
          end
          ST_ACKR: begin
            // Master not acknowledging ends the read
            if (scl_rise && sda_s2) begin
              state_reg <= ST_IDLE;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
        // Reads load a byte on the SCL fall that ends an ACK phase
        // A low-byte read freezes that channel's high byte at once
        if (load_rd) begin
          tx_reg <= rd_data;
          sda_oe_reg <= ~rd_data[7];
          bit_cnt_reg <= 4'h0;
          state_reg <= ST_RD;
          rd_idx_reg <= rd_idx_reg + 4'h1;
          if (rd_addr == `OFS_CHAN0_LOW) begin
            chan0_shadow_reg <= chan0_result_reg[15:8];
          end
          if (rd_addr == `OFS_CHAN1_LOW) begin
            chan1_shadow_reg <= chan1_result_reg[15:8];
          end
        end
      end
    end
  end

  // Window check on channel 0 only
  wire outside = (chan0_sample <= low_limit_reg) |
    (chan0_sample > high_limit_reg);
  wire [3:0] cnt_inc = (persist_cnt_reg == `PERSIST_MAX) ?
    persist_cnt_reg : persist_cnt_reg + 4'h1;
  wire level_mode = (mode == `MODE_LEVEL);
  wire fire = conv_done & level_mode &
    ((persist == `PERSIST_EVERY) |
     (outside & (cnt_inc >= persist)));

  // Results, persistence and pending flag
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      chan0_result_reg <= `RESULT_RESET;
      chan1_result_reg <= `RESULT_RESET;
      persist_cnt_reg <= 4'h0;
      pending_reg <= 1'b0;
      int_n_reg <= 1'b1;
    end else begin
      if (conv_done) begin
        // Shadows are untouched here, so they keep their latched value
        chan0_result_reg <= chan0_sample;
        chan1_result_reg <= chan1_sample;
        if (level_mode && outside) begin
          persist_cnt_reg <= cnt_inc;
        end else begin
          persist_cnt_reg <= 4'h0;
        end
      end
      // A new event wins over a clear in the same cycle
      if (fire) begin
        pending_reg <= 1'b1;
      end else if (clear_reg) begin
        pending_reg <= 1'b0;
      end
      int_n_reg <= ~((fire | (pending_reg & ~clear_reg)) &
        level_mode);
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_reg;
  assign int_n = int_n_reg;

endmodule // light_sensor_irq_and_data_regs

/* File: light_sensor_consts.vh */
`ifndef LIGHT_SENSOR_CONSTS_VH
`define LIGHT_SENSOR_CONSTS_VH

// Bus address of the device (7 bits); plain default
`define BUS_ADDR_DEFAULT 7'h2a

// Register offsets (command pointer values)
`define OFS_LOW_LIMIT_LO 4'h2
`define OFS_LOW_LIMIT_HI 4'h3
`define OFS_HIGH_LIMIT_LO 4'h4
`define OFS_HIGH_LIMIT_HI 4'h5
`define OFS_IRQ_CONTROL 4'h6
`define OFS_PART_IDENTITY 4'ha
`define OFS_CHAN0_LOW 4'hc
`define OFS_CHAN0_HIGH 4'hd
`define OFS_CHAN1_LOW 4'he
`define OFS_CHAN1_HIGH 4'hf

// Command byte fields
`define CMD_SELECT_BIT 7
`define CMD_CLEAR_BIT 6
`define CMD_WORD_BIT 5

// Control register fields and codes
`define MODE_MSB 5
`define MODE_LSB 4
`define PERSIST_MSB 3
`define PERSIST_LSB 0
`define MODE_DISABLED 2'h0
`define MODE_LEVEL 2'h1
`define PERSIST_EVERY 4'h0
`define PERSIST_MAX 4'hf

// Identity fields; values are arbitrary
`define PART_CODE_VALUE 4'h5
`define SILICON_REV_VALUE 4'h1

// Reset values
`define COMMAND_RESET 8'h00
`define IRQ_CONTROL_RESET 8'h00
`define RESULT_RESET 16'h0000
`define LIMIT_RESET 16'h0000

// Bits in one bus byte
`define BITS_PER_BYTE 4'h8

`endif

/* File: light_sensor_monitor.sv */
`timescale 1ns/100ps
module light_sensor_monitor (
  input wire core_clk,
  input wire rstn,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire conv_done,
  input wire [15:0] chan0_sample,
  input wire [15:0] chan1_sample,
  input wire int_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_oe_after_fall: assert property ($rose(sda_oe) |->
    !sda_out && $past(scl_in, 4) && !$past(scl_in, 3))
    else $error("sda_oe rose out of step with the scl fall");
  a_int_holds_low: assert property (!int_n && !sda_oe |=> !int_n)
    else $error("int_n released without a command byte");
  a_fire_needs_conv: assert property ($fell(int_n) |-> $past(conv_done))
    else $error("int_n fell without a conversion");
  a_clear_at_ack: assert property ($rose(int_n) |-> ##[0:4] sda_oe)
    else $error("int_n released outside an acknowledged byte");
  a_reset_int_high: assert property ($rose(rstn) |-> int_n[*2])
    else $error("int_n low after reset");
  a_reset_oe_low: assert property ($rose(rstn) |-> !sda_oe[*3])
    else $error("sda_oe high after reset");
  a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("sda_oe rose while scl high");
  a_oe_fall_low: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("sda_oe fell while scl high");
  a_ack_stands: assert property ($rose(sda_oe) |-> sda_oe[*6])
    else $error("sda_oe bit too short");
endmodule // light_sensor_monitor

/* File: i2c_host_model.sv */
`timescale 1ns/100ps
module i2c_host_model #(
  parameter [6:0] ADDR = 7'h2a
) (
  input wire sda_line,
  output logic scl,
  output logic sda_low
);
  int nacks = 0;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Data moves only while scl is low; sampled late in the high phase
  // Steps are whole multiples of 20 ns, so pins never move on a rising edge
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    #40 sda_low = !b;
    #40 scl = 1'b1;
    #60 r = sda_line;
    #20;
  endtask
  task automatic start();
    scl = 1'b0;
    #40 sda_low = 1'b0;
    #40 scl = 1'b1;
    #40 sda_low = 1'b1;
    #40;
  endtask
  task automatic stop();
    scl = 1'b0;
    #40 sda_low = 1'b1;
    #40 scl = 1'b1;
    #40 sda_low = 1'b0;
    #40;
  endtask
  task automatic wr(input logic [7:0] d);
    logic [7:0] q;
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(1'b1, a);
    if (a) nacks++;
  endtask
  task automatic rd(input logic last, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, q[i]);
    bit_io(last, a);
  endtask
  // Limits always go as one word, low byte first
  task automatic wr_word(input logic [3:0] ofs, input logic [15:0] w);
    start();
    wr({ADDR, 1'b0});
    wr({4'ha, ofs});
    wr(w[7:0]);
    wr(w[15:8]);
    stop();
  endtask
  task automatic send(input logic [7:0] c);
    start();
    wr({ADDR, 1'b0});
    wr(c);
    stop();
  endtask
  // Low byte is always read before its high byte
  task automatic rd_word(input logic [3:0] ofs, output logic [15:0] w);
    start();
    wr({ADDR, 1'b0});
    wr({4'ha, ofs});
    start();
    wr({ADDR, 1'b1});
    rd(1'b0, w[7:0]);
    rd(1'b1, w[15:8]);
    stop();
  endtask
  task automatic rd_byte(output logic [7:0] b);
    start();
    wr({ADDR, 1'b1});
    rd(1'b1, b);
    stop();
  endtask
endmodule // i2c_host_model

/* File: testbench.sv */
`timescale 1ns/100ps
`include "light_sensor_consts.vh"
module testbench;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic conv_done = 1'b0;
  logic [15:0] chan0_sample = 16'h0000;
  logic [15:0] chan1_sample = 16'h0000;
  wire scl, sda_low, sda_out, sda_oe, int_n;
  // Pull-up line: low when either party pulls it
  wire sda_line = !sda_low && (sda_oe ? sda_out : 1'b1);
  int num_errors = 0;
  int n_checks = 0;
  int seed = 10013;
  logic [15:0] lo_lim, hi_lim, w, v1, v2;
  logic [7:0] b, r;
  logic [5:0] ctl = 6'h00;
  logic pend = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [5:0] ctl_tab [7] = '{6'h10, 6'h11, 6'h12, 6'h15, 6'h1f, 6'h03, 6'h21};
  light_sensor_irq_and_data_regs u_light_sensor_irq_and_data_regs (
    .core_clk(core_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .conv_done(conv_done),
    .chan0_sample(chan0_sample), .chan1_sample(chan1_sample), .int_n(int_n));
  i2c_host_model u_i2c_host_model (
    .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  initial forever #10 core_clk = !core_clk;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors=%0d checks=%0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic conv(input logic [15:0] c0, input logic [15:0] c1);
    logic out, lvl;
    @(negedge core_clk);
    chan0_sample = c0;
    chan1_sample = c1;
    conv_done = 1'b1;
    @(negedge core_clk);
    conv_done = 1'b0;
    lvl = ctl[5:4] == `MODE_LEVEL;
    out = c0 <= lo_lim || c0 > hi_lim;
    cnt = (out && lvl) ? (cnt == 4'hf ? cnt : cnt + 4'h1) : 4'h0;
    if (lvl && (ctl[3:0] == 4'h0 || (out && cnt >= ctl[3:0]))) pend = 1'b1;
    @(negedge core_clk);
    check(int_n, !(pend && lvl));
  endtask
  initial begin
    repeat (4) @(negedge core_clk);
    rstn = 1'b1;
    repeat (4) @(negedge core_clk);
    check(int_n, 1'b1);
    u_i2c_host_model.rd_word(`OFS_CHAN0_LOW, w);
    check(w, `RESULT_RESET);
    u_i2c_host_model.rd_word(`OFS_CHAN1_LOW, w);
    check(w, `RESULT_RESET);
    u_i2c_host_model.send(8'h8a);
    u_i2c_host_model.rd_byte(b);
    check(b, {`PART_CODE_VALUE, `SILICON_REV_VALUE});
    lo_lim = 16'($random(seed)) & 16'h3fff;
    hi_lim = lo_lim + 16'h4000;
    u_i2c_host_model.wr_word(`OFS_LOW_LIMIT_LO, lo_lim);
    u_i2c_host_model.wr_word(`OFS_HIGH_LIMIT_LO, hi_lim);
    u_i2c_host_model.rd_word(`OFS_LOW_LIMIT_LO, w);
    check(w, lo_lim);
    u_i2c_host_model.rd_word(`OFS_HIGH_LIMIT_LO, w);
    check(w, hi_lim);
    foreach (ctl_tab[k]) begin
      ctl = ctl_tab[k];
      u_i2c_host_model.wr_word(`OFS_IRQ_CONTROL, {10'h000, ctl});
      u_i2c_host_model.rd_word(`OFS_IRQ_CONTROL, w);
      check(w, {10'h000, ctl});
      // One two-sample outside run, then a 15-sample one, then random mix
      for (int j = 0; j < 24; j++) begin
        r = 8'($random(seed));
        if (j == 0 || j == 3 || (j > 18 && r[1]))
          conv(r[0] ? lo_lim + 16'h1 : hi_lim, 16'($random(seed)));
        else
          conv(r[0] ? lo_lim : hi_lim + 16'h1, 16'($random(seed)));
      end
      u_i2c_host_model.send(8'hc6);
      pend = 1'b0;
      repeat (2) @(negedge core_clk);
      check(int_n, 1'b1);
    end
    for (int ch = 0; ch < 2; ch++) begin
      v1 = 16'($random(seed));
      v2 = ~v1;
      conv(v1, v1);
      u_i2c_host_model.send(8'h8c + 8'(2 * ch));
      u_i2c_host_model.rd_byte(b);
      check(b, v1[7:0]);
      conv(v2, v2);
      u_i2c_host_model.send(8'h8d + 8'(2 * ch));
      u_i2c_host_model.rd_byte(b);
      check(b, v1[15:8]);
      u_i2c_host_model.wr_word(4'hc + 4'(2 * ch), ~v2);
      u_i2c_host_model.rd_word(4'hc + 4'(2 * ch), w);
      check(w, v2);
    end
    u_i2c_host_model.send(8'h88);
    u_i2c_host_model.rd_byte(b);
    check(b, 8'h00);
    check(16'(u_i2c_host_model.nacks), 16'h0000);
    stop_test();
  end
endmodule // testbench
bind light_sensor_irq_and_data_regs light_sensor_monitor u_light_sensor_monitor (
  .core_clk(core_clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .conv_done(conv_done),
  .chan0_sample(chan0_sample), .chan1_sample(chan1_sample), .int_n(int_n));
